// ---- include/bsb_exec_defs.vh ----
`ifndef BSB_EXEC_DEFS_VH
`define BSB_EXEC_DEFS_VH

`define BSB_OP_W 5
`define BSB_OP_CLR_CARRY 5'h00
`define BSB_OP_SET_CARRY 5'h01
`define BSB_OP_INV_CARRY 5'h02
`define BSB_OP_CLR_BIT 5'h03
`define BSB_OP_SET_BIT 5'h04
`define BSB_OP_INV_BIT 5'h05
`define BSB_OP_AND_C 5'h06
`define BSB_OP_AND_NC 5'h07
`define BSB_OP_OR_C 5'h08
`define BSB_OP_OR_NC 5'h09
`define BSB_OP_MOV_TO_C 5'h0A
`define BSB_OP_MOV_FROM_C 5'h0B
`define BSB_OP_SWAP 5'h0C
`define BSB_OP_SWAP_NIB 5'h0D
`define BSB_OP_PUSH 5'h0E
`define BSB_OP_POP 5'h0F
`define BSB_OP_BRANCH 5'h10

`define BSB_FORM_REG 3'h0
`define BSB_FORM_DIR 3'h1
`define BSB_FORM_IND 3'h2
`define BSB_FORM_SDIR 3'h0
`define BSB_FORM_IMM8 3'h1
`define BSB_FORM_IMM16 3'h2
`define BSB_FORM_BYTE 3'h3
`define BSB_FORM_WORD 3'h4
`define BSB_FORM_DWORD 3'h5

`define BSB_KIND_RAM 2'h0
`define BSB_KIND_PORT 2'h1
`define BSB_KIND_PSFR 2'h2

`define BSB_CC_CARRY 4'h0
`define BSB_CC_NCARRY 4'h1
`define BSB_CC_EQ 4'h2
`define BSB_CC_NE 4'h3
`define BSB_CC_GT 4'h4
`define BSB_CC_LE 4'h5
`define BSB_CC_SLT 4'h6
`define BSB_CC_SLE 4'h7
`define BSB_CC_SGT 4'h8
`define BSB_CC_SGE 4'h9

`define BSB_RD_PEN_PORT 4'h1
`define BSB_RD_PEN_PSFR 4'h2
`define BSB_WR_PEN_PORT 4'h2
`define BSB_WR_PEN_PSFR 4'h3
`define BSB_ODD_PEN 4'h1

`define BSB_SP_RESET 16'h0007
`define BSB_PC_RESET 24'hFF0000
`define BSB_CARRY_RESET 1'b0

`endif

// ---- logic/bsb_timing.v ----
`timescale 1ns/10ps
`include "bsb_exec_defs.vh"

module bsb_timing (
  // instruction description
  input wire [4:0] op,
  input wire [2:0] form,
  input wire legacy,
  input wire src_mode,
  input wire [1:0] kind,
  input wire flag_cond,
  // branch outcome
  input wire taken,
  input wire odd_dest,
  // results
  output reg [3:0] states,
  output reg [2:0] len
);

  reg [3:0] rd_pen;
  reg [3:0] wr_pen;
  reg [3:0] base;

  always @* begin
    rd_pen = 4'h0;
    wr_pen = 4'h0;
    if (kind == `BSB_KIND_PORT) begin
      rd_pen = `BSB_RD_PEN_PORT;
      wr_pen = `BSB_WR_PEN_PORT;
    end else if (kind == `BSB_KIND_PSFR) begin
      rd_pen = `BSB_RD_PEN_PSFR;
      wr_pen = `BSB_WR_PEN_PSFR;
    end
  end

  // length never depends on the branch outcome, so the target adder has no loop
  always @* begin
    len = 3'h1;
    case (op)
      `BSB_OP_CLR_CARRY, `BSB_OP_SET_CARRY, `BSB_OP_INV_CARRY: len = 3'h1;
      `BSB_OP_CLR_BIT, `BSB_OP_SET_BIT, `BSB_OP_INV_BIT, `BSB_OP_AND_C, `BSB_OP_AND_NC,
      `BSB_OP_OR_C, `BSB_OP_OR_NC, `BSB_OP_MOV_TO_C, `BSB_OP_MOV_FROM_C: begin
        len = legacy ? 3'h2 : (src_mode ? 3'h3 : 3'h4);
      end
      `BSB_OP_SWAP, `BSB_OP_SWAP_NIB: begin
        len = (form == `BSB_FORM_DIR) ? 3'h2 : (src_mode ? 3'h2 : 3'h1);
      end
      `BSB_OP_PUSH: begin
        case (form)
          `BSB_FORM_SDIR: len = 3'h2;
          `BSB_FORM_IMM8: len = src_mode ? 3'h3 : 3'h4;
          `BSB_FORM_IMM16: len = src_mode ? 3'h4 : 3'h5;
          default: len = src_mode ? 3'h2 : 3'h3;
        endcase
      end
      `BSB_OP_POP: len = (form == `BSB_FORM_SDIR) ? 3'h2 : (src_mode ? 3'h2 : 3'h3);
      `BSB_OP_BRANCH: len = (flag_cond | src_mode) ? 3'h2 : 3'h3;
      default: len = 3'h1;
    endcase
  end

  always @* begin
    base = 4'h1;
    case (op)
      `BSB_OP_CLR_CARRY, `BSB_OP_SET_CARRY, `BSB_OP_INV_CARRY: base = 4'h1;
      `BSB_OP_CLR_BIT, `BSB_OP_SET_BIT, `BSB_OP_INV_BIT, `BSB_OP_MOV_FROM_C: begin
        base = (legacy ? 4'h2 : (src_mode ? 4'h3 : 4'h4)) + wr_pen;
      end
      `BSB_OP_AND_C, `BSB_OP_AND_NC, `BSB_OP_OR_C, `BSB_OP_OR_NC, `BSB_OP_MOV_TO_C: begin
        base = (legacy ? 4'h1 : (src_mode ? 4'h2 : 4'h3)) + rd_pen;
      end
      `BSB_OP_SWAP, `BSB_OP_SWAP_NIB: begin
        case (form)
          `BSB_FORM_DIR: base = 4'h3 + wr_pen;
          `BSB_FORM_IND: base = src_mode ? 4'h5 : 4'h4;
          default: base = src_mode ? 4'h4 : 4'h3;
        endcase
      end
      `BSB_OP_PUSH: begin
        case (form)
          `BSB_FORM_SDIR: base = 4'h2 + rd_pen;
          `BSB_FORM_IMM8: base = src_mode ? 4'h3 : 4'h4;
          `BSB_FORM_IMM16: base = 4'h5;
          `BSB_FORM_BYTE: base = src_mode ? 4'h3 : 4'h4;
          `BSB_FORM_WORD: base = src_mode ? 4'h4 : 4'h5;
          default: base = src_mode ? 4'h8 : 4'h9;
        endcase
      end
      `BSB_OP_POP: begin
        case (form)
          `BSB_FORM_SDIR: base = 4'h3 + rd_pen;
          `BSB_FORM_WORD: base = src_mode ? 4'h4 : 4'h5;
          `BSB_FORM_DWORD: base = src_mode ? 4'h8 : 4'h9;
          default: base = src_mode ? 4'h2 : 4'h3;
        endcase
      end
      `BSB_OP_BRANCH: begin
        base = (flag_cond | src_mode) ? 4'h1 : 4'h2;
        if (taken) begin
          base = base + 4'h3;
        end
      end
      default: base = 4'h1;
    endcase
  end

  always @* begin
    states = base;
    if ((op == `BSB_OP_BRANCH) && taken && odd_dest) begin
      states = base + `BSB_ODD_PEN;
    end
  end

endmodule // bsb_timing

// ---- logic/bsb_exec.v ----
`timescale 1ns/10ps
`include "bsb_exec_defs.vh"

module bsb_exec #(
  parameter PC_W = 24,
  parameter SP_W = 16
) (
  // clock and reset
  input wire SYS_CLK,
  input wire RST,
  // instruction issue, from decode logic on the same clock
  input wire START,
  input wire [4:0] OP,
  input wire [2:0] FORM,
  input wire LEGACY,
  input wire SRC_MODE,
  input wire [1:0] KIND,
  input wire [3:0] COND,
  input wire [7:0] REL,
  input wire [PC_W-1:0] INSTR_PC,
  input wire INT_EXEC,
  input wire DEST_INTERNAL,
  // operands and flags
  input wire BIT_IN,
  input wire [7:0] ACC_IN,
  input wire [31:0] OPND_IN,
  input wire FLAG_Z,
  input wire FLAG_N,
  input wire FLAG_OV,
  // sequencing
  output wire BUSY,
  output wire DONE,
  output wire ILLEGAL,
  output wire [3:0] STATES,
  output wire [2:0] LENGTH,
  // carry and bit results
  output wire CARRY,
  output wire BIT_OUT,
  output wire BIT_WE,
  // exchange results
  output wire [7:0] ACC_OUT,
  output wire ACC_WE,
  output wire [7:0] MEM_OUT,
  output wire MEM_WE,
  // stack
  output wire [SP_W-1:0] SP,
  output wire [SP_W-1:0] STK_ADDR,
  output wire [31:0] STK_DATA,
  output wire [2:0] STK_SIZE,
  output wire STK_WE,
  output wire STK_RE,
  // program counter
  output wire [PC_W-1:0] NEXT_PC,
  output wire PC_WE,
  output wire TAKEN
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  reg state_r;
  reg [3:0] count_r;
  reg busy_r;
  reg done_r;
  reg illegal_r;
  reg [3:0] states_r;
  reg [2:0] length_r;
  reg carry_r;
  reg bit_out_r;
  reg bit_we_r;
  reg [7:0] acc_out_r;
  reg acc_we_r;
  reg [7:0] mem_out_r;
  reg mem_we_r;
  reg [SP_W-1:0] sp_r;
  reg [SP_W-1:0] stk_addr_r;
  reg [31:0] stk_data_r;
  reg [2:0] stk_size_r;
  reg stk_we_r;
  reg stk_re_r;
  reg [PC_W-1:0] next_pc_r;
  reg pc_we_r;
  reg taken_r;

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  wire accept = START & (state_r == ST_IDLE);
  wire flag_cond = (COND == `BSB_CC_CARRY) | (COND == `BSB_CC_NCARRY);
  wire sign_lt = FLAG_N ^ FLAG_OV;
  reg cond_true;
  reg legal;
  reg [2:0] opnd_size;
  reg carry_nxt;
  reg bit_nxt;
  reg bit_wr;

  always @* begin
    case (COND)
      `BSB_CC_CARRY: cond_true = carry_r;
      `BSB_CC_NCARRY: cond_true = ~carry_r;
      `BSB_CC_EQ: cond_true = FLAG_Z;
      `BSB_CC_NE: cond_true = ~FLAG_Z;
      `BSB_CC_GT: cond_true = ~carry_r & ~FLAG_Z;
      `BSB_CC_LE: cond_true = carry_r | FLAG_Z;
      `BSB_CC_SLT: cond_true = sign_lt;
      `BSB_CC_SLE: cond_true = sign_lt | FLAG_Z;
      `BSB_CC_SGT: cond_true = ~sign_lt & ~FLAG_Z;
      `BSB_CC_SGE: cond_true = ~sign_lt;
      default: cond_true = 1'b0;
    endcase
  end

  // unknown codes retire as one-state no-ops so the sequencer never stalls
  always @* begin
    legal = (OP <= `BSB_OP_BRANCH);
    if ((OP == `BSB_OP_BRANCH) && (COND > `BSB_CC_SGE)) begin
      legal = 1'b0;
    end
    if (((OP == `BSB_OP_PUSH) || (OP == `BSB_OP_POP)) && (FORM > `BSB_FORM_DWORD)) begin
      legal = 1'b0;
    end
    if ((OP == `BSB_OP_POP) && ((FORM == `BSB_FORM_IMM8) || (FORM == `BSB_FORM_IMM16))) begin
      legal = 1'b0;
    end
    if ((OP == `BSB_OP_SWAP_NIB) && (FORM != `BSB_FORM_IND)) begin
      legal = 1'b0;
    end
    if (((OP == `BSB_OP_SWAP) || (OP == `BSB_OP_SWAP_NIB)) && (FORM > `BSB_FORM_IND)) begin
      legal = 1'b0;
    end
  end

  always @* begin
    case (FORM)
      `BSB_FORM_IMM16, `BSB_FORM_WORD: opnd_size = 3'h2;
      `BSB_FORM_DWORD: opnd_size = 3'h4;
      default: opnd_size = 3'h1;
    endcase
  end

  always @* begin
    carry_nxt = carry_r;
    bit_nxt = 1'b0;
    bit_wr = 1'b0;
    case (OP)
      `BSB_OP_CLR_CARRY: carry_nxt = 1'b0;
      `BSB_OP_SET_CARRY: carry_nxt = 1'b1;
      `BSB_OP_INV_CARRY: carry_nxt = ~carry_r;
      `BSB_OP_AND_C: carry_nxt = carry_r & BIT_IN;
      `BSB_OP_AND_NC: carry_nxt = carry_r & ~BIT_IN;
      `BSB_OP_OR_C: carry_nxt = carry_r | BIT_IN;
      `BSB_OP_OR_NC: carry_nxt = carry_r | ~BIT_IN;
      `BSB_OP_MOV_TO_C: carry_nxt = BIT_IN;
      `BSB_OP_CLR_BIT: begin
        bit_nxt = 1'b0;
        bit_wr = 1'b1;
      end
      `BSB_OP_SET_BIT: begin
        bit_nxt = 1'b1;
        bit_wr = 1'b1;
      end
      `BSB_OP_INV_BIT: begin
        bit_nxt = ~BIT_IN;
        bit_wr = 1'b1;
      end
      `BSB_OP_MOV_FROM_C: begin
        bit_nxt = carry_r;
        bit_wr = 1'b1;
      end
      default: carry_nxt = carry_r;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // branch target and timing

  wire br_taken = (OP == `BSB_OP_BRANCH) & legal & cond_true;
  wire [2:0] len;
  wire [3:0] states;
  wire [PC_W-1:0] rel_ext = {{(PC_W-8){REL[7]}}, REL};
  wire [PC_W-1:0] fall_pc = INSTR_PC + {{(PC_W-3){1'b0}}, len};
  wire [PC_W-1:0] target_pc = fall_pc + rel_ext;
  wire odd_dest = INT_EXEC & DEST_INTERNAL & target_pc[0];

  bsb_timing bsb_timing_i (
    .op(OP),
    .form(FORM),
    .legacy(LEGACY),
    .src_mode(SRC_MODE),
    .kind(KIND),
    .flag_cond(flag_cond),
    .taken(br_taken),
    .odd_dest(odd_dest),
    .states(states),
    .len(len)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer: results land one cycle after issue, busy covers the state count

  always @(posedge SYS_CLK) begin
    if (RST) begin
      state_r <= ST_IDLE;
      count_r <= 4'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (accept) begin
            state_r <= ST_RUN;
            busy_r <= 1'b1;
            count_r <= legal ? (states - 4'h1) : 4'h0;
          end
        end
        ST_RUN: begin
          if (count_r == 4'h0) begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end else begin
            count_r <= count_r - 4'h1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // architectural results

  wire is_swap = (OP == `BSB_OP_SWAP) | (OP == `BSB_OP_SWAP_NIB);
  // stack pointer wraps modulo its width; no overflow check is made here
  wire [SP_W-1:0] size_ext = {{(SP_W-3){1'b0}}, opnd_size};
  wire [SP_W-1:0] sp_inc = sp_r + {{(SP_W-1){1'b0}}, 1'b1};
  wire [SP_W-1:0] sp_pop_addr = sp_r - size_ext + {{(SP_W-1){1'b0}}, 1'b1};

  always @(posedge SYS_CLK) begin
    if (RST) begin
      illegal_r <= 1'b0;
      states_r <= 4'h0;
      length_r <= 3'h0;
      carry_r <= `BSB_CARRY_RESET;
      bit_out_r <= 1'b0;
      bit_we_r <= 1'b0;
      acc_out_r <= 8'h00;
      acc_we_r <= 1'b0;
      mem_out_r <= 8'h00;
      mem_we_r <= 1'b0;
      sp_r <= `BSB_SP_RESET;
      stk_addr_r <= {SP_W{1'b0}};
      stk_data_r <= 32'h00000000;
      stk_size_r <= 3'h0;
      stk_we_r <= 1'b0;
      stk_re_r <= 1'b0;
      next_pc_r <= `BSB_PC_RESET;
      pc_we_r <= 1'b0;
      taken_r <= 1'b0;
    end else begin
      illegal_r <= 1'b0;
      bit_we_r <= 1'b0;
      acc_we_r <= 1'b0;
      mem_we_r <= 1'b0;
      stk_we_r <= 1'b0;
      stk_re_r <= 1'b0;
      pc_we_r <= 1'b0;
      if (accept) begin
        illegal_r <= ~legal;
        states_r <= legal ? states : 4'h1;
        length_r <= len;
        taken_r <= br_taken;
        pc_we_r <= 1'b1;
        next_pc_r <= br_taken ? target_pc : fall_pc;
        if (legal) begin
          carry_r <= carry_nxt;
          bit_out_r <= bit_nxt;
          bit_we_r <= bit_wr;
        end
        if (legal && is_swap) begin
          if (OP == `BSB_OP_SWAP_NIB) begin
            acc_out_r <= {ACC_IN[7:4], OPND_IN[3:0]};
            mem_out_r <= {OPND_IN[7:4], ACC_IN[3:0]};
          end else begin
            acc_out_r <= OPND_IN[7:0];
            mem_out_r <= ACC_IN;
          end
          acc_we_r <= 1'b1;
          mem_we_r <= 1'b1;
        end
        if (legal && (OP == `BSB_OP_PUSH)) begin
          stk_addr_r <= sp_inc;
          sp_r <= sp_r + size_ext;
          stk_data_r <= OPND_IN;
          stk_size_r <= opnd_size;
          stk_we_r <= 1'b1;
        end
        if (legal && (OP == `BSB_OP_POP)) begin
          stk_addr_r <= sp_pop_addr;
          sp_r <= sp_r - size_ext;
          stk_size_r <= opnd_size;
          stk_re_r <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign BUSY = busy_r;
  assign DONE = done_r;
  assign ILLEGAL = illegal_r;
  assign STATES = states_r;
  assign LENGTH = length_r;
  assign CARRY = carry_r;
  assign BIT_OUT = bit_out_r;
  assign BIT_WE = bit_we_r;
  assign ACC_OUT = acc_out_r;
  assign ACC_WE = acc_we_r;
  assign MEM_OUT = mem_out_r;
  assign MEM_WE = mem_we_r;
  assign SP = sp_r;
  assign STK_ADDR = stk_addr_r;
  assign STK_DATA = stk_data_r;
  assign STK_SIZE = stk_size_r;
  assign STK_WE = stk_we_r;
  assign STK_RE = stk_re_r;
  assign NEXT_PC = next_pc_r;
  assign PC_WE = pc_we_r;
  assign TAKEN = taken_r;

endmodule // bsb_exec

// ---- tb/bsb_exec_props.sv ----
`timescale 1ns/10ps
`include "bsb_exec_defs.vh"

module bsb_exec_props #(
  parameter PC_W = 24,
  parameter SP_W = 16
) (
  // clock and reset
  input wire SYS_CLK,
  input wire RST,
  // issue
  input wire START,
  input wire [4:0] OP,
  input wire SRC_MODE,
  input wire [3:0] COND,
  input wire [7:0] REL,
  input wire [PC_W-1:0] INSTR_PC,
  input wire INT_EXEC,
  input wire DEST_INTERNAL,
  input wire BIT_IN,
  // results
  input wire BUSY,
  input wire DONE,
  input wire ILLEGAL,
  input wire [3:0] STATES,
  input wire [2:0] LENGTH,
  input wire CARRY,
  input wire [SP_W-1:0] SP,
  input wire [SP_W-1:0] STK_ADDR,
  input wire [2:0] STK_SIZE,
  input wire STK_WE,
  input wire STK_RE,
  input wire [PC_W-1:0] NEXT_PC,
  input wire PC_WE,
  input wire TAKEN
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  wire acc = START && !BUSY;
  wire flag_br = acc && OP == `BSB_OP_BRANCH && COND > 4'h1 && COND < 4'hA;
  reg [3:0] n_r;
  reg [PC_W-1:0] pc_r;
  reg [PC_W-1:0] rel_r;
  reg ie_r;

  ////////////////////////////////////////////////////////////////////////////////
  // busy cycles counted so the done pulse can be tied to the reported count
  always @(posedge SYS_CLK) begin
    if (RST || !BUSY)
      n_r <= 4'h0;
    else
      n_r <= n_r + 4'h1;
    if (acc) begin
      pc_r <= INSTR_PC;
      rel_r <= {{(PC_W-8){REL[7]}}, REL};
      ie_r <= INT_EXEC && DEST_INTERNAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_done_span: assert property (DONE |-> n_r == STATES)
    else $error("done out of step with state count");
  a_push_seq: assert property (acc && OP == `BSB_OP_PUSH |=> ILLEGAL ||
    (STK_WE && STK_ADDR == $past(SP) + 1'b1 && SP == $past(SP) + STK_SIZE))
    else $error("push address or pointer wrong");
  a_pop_seq: assert property (acc && OP == `BSB_OP_POP |=> ILLEGAL ||
    (STK_RE && STK_ADDR == $past(SP) - STK_SIZE + 1'b1 && SP == STK_ADDR - 1'b1))
    else $error("pop address or pointer wrong");
  a_branch_pc: assert property (acc && OP == `BSB_OP_BRANCH && COND < 4'hA
    |=> PC_WE && NEXT_PC == pc_r + LENGTH + (rel_r & {PC_W{TAKEN}}))
    else $error("branch target wrong");
  a_branch_pair: assert property (flag_br && !SRC_MODE
    |=> STATES == (TAKEN ? 4'h5 + (ie_r & NEXT_PC[0]) : 4'h2))
    else $error("flag branch state count wrong");
  a_carry_and: assert property (acc && OP == `BSB_OP_AND_C
    |=> CARRY == ($past(CARRY) & $past(BIT_IN)))
    else $error("and into carry wrong");
  a_carry_ornot: assert property (acc && OP == `BSB_OP_OR_NC
    |=> CARRY == ($past(CARRY) | !$past(BIT_IN)))
    else $error("or inverse into carry wrong");
  a_carry_ops: assert property (acc && OP <= `BSB_OP_INV_CARRY
    |=> STATES == 4'h1 && LENGTH == 3'h1)
    else $error("carry op not single state");
  a_busy_hold: assert property (BUSY |=> $stable(STATES) && $stable(SP))
    else $error("result moved while busy");

  c_push: cover property (acc && OP == `BSB_OP_PUSH);
  c_taken: cover property (TAKEN && PC_WE);
  c_refused: cover property (START && BUSY);
endmodule  // bsb_exec_props

bind bsb_exec bsb_exec_props #(.PC_W(PC_W), .SP_W(SP_W)) bsb_exec_props_i (
  .SYS_CLK(SYS_CLK), .RST(RST), .START(START), .OP(OP), .SRC_MODE(SRC_MODE),
  .COND(COND), .REL(REL), .INSTR_PC(INSTR_PC), .INT_EXEC(INT_EXEC),
  .DEST_INTERNAL(DEST_INTERNAL), .BIT_IN(BIT_IN), .BUSY(BUSY), .DONE(DONE),
  .ILLEGAL(ILLEGAL), .STATES(STATES), .LENGTH(LENGTH), .CARRY(CARRY), .SP(SP),
  .STK_ADDR(STK_ADDR), .STK_SIZE(STK_SIZE), .STK_WE(STK_WE), .STK_RE(STK_RE),
  .NEXT_PC(NEXT_PC), .PC_WE(PC_WE), .TAKEN(TAKEN));

// ---- tb/tb_bsb_exec.sv ----
`timescale 1ns/10ps
`include "bsb_exec_defs.vh"

module tb_bsb_exec;
  reg clk = 1'b0, rst = 1'b1, start = 1'b0, legacy = 1'b0, src = 1'b0;
  reg int_exec = 1'b0, dest_int = 1'b0, bit_in = 1'b0;
  reg flag_z = 1'b0, flag_n = 1'b0, flag_ov = 1'b0;
  reg [4:0] op = 5'h00;
  reg [2:0] form = 3'h0;
  reg [1:0] kind = 2'h0;
  reg [3:0] cond = 4'h0;
  reg [7:0] rel = 8'hFC, acc_in = 8'h5A;
  reg [23:0] ipc = 24'h000100;
  reg [31:0] opnd = 32'h1234ABC3;
  wire busy, done, illegal, carry, bit_out, bit_we, acc_we, mem_we, stk_we, stk_re, pc_we, taken;
  wire [3:0] states;
  wire [2:0] len, stk_size;
  wire [7:0] acc_out, mem_out;
  wire [15:0] sp, stk_addr;
  wire [31:0] stk_data;
  wire [23:0] next_pc;
  reg [6:0] pl;
  reg ecy;
  reg [15:0] esp;
  integer n_mismatch = 0, checks_done = 0;

  always #12.5 clk = ~clk;

  bsb_exec bsb_exec_i (
    .SYS_CLK(clk), .RST(rst), .START(start), .OP(op), .FORM(form), .LEGACY(legacy),
    .SRC_MODE(src), .KIND(kind), .COND(cond), .REL(rel), .INSTR_PC(ipc), .INT_EXEC(int_exec),
    .DEST_INTERNAL(dest_int), .BIT_IN(bit_in), .ACC_IN(acc_in), .OPND_IN(opnd),
    .FLAG_Z(flag_z), .FLAG_N(flag_n), .FLAG_OV(flag_ov), .BUSY(busy), .DONE(done),
    .ILLEGAL(illegal),
    .STATES(states), .LENGTH(len), .CARRY(carry), .BIT_OUT(bit_out), .BIT_WE(bit_we),
    .ACC_OUT(acc_out), .ACC_WE(acc_we), .MEM_OUT(mem_out), .MEM_WE(mem_we), .SP(sp),
    .STK_ADDR(stk_addr), .STK_DATA(stk_data), .STK_SIZE(stk_size), .STK_WE(stk_we),
    .STK_RE(stk_re), .NEXT_PC(next_pc), .PC_WE(pc_we), .TAKEN(taken));

  ////////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] v);
    begin
      checks_done = checks_done + 1;
      if (e !== v) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %s expected %0h seen %0h", nm, e, v);
      end
    end
  endtask

  function [3:0] tm(input l, input s, input [1:0] k, input w);
    tm = (l ? 4'h1 : s ? 4'h2 : 4'h3) + w + (k == 2'h1 ? 4'h1 + w : k == 2'h2 ? 4'h2 + w : 4'h0);
  endfunction

  function [2:0] ln(input l, input s);
    ln = l ? 3'h2 : s ? 3'h3 : 3'h4;
  endfunction

  // entered just after an edge; pulses are caught in the cycle after acceptance
  task run(input [4:0] o, input [2:0] f, input l, input s, input [1:0] k, input [3:0] st,
    input [2:0] lv);
    integer n;
    begin
      op = o;
      form = f;
      legacy = l;
      src = s;
      kind = k;
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      pl = {bit_we, acc_we, mem_we, stk_we, stk_re, pc_we, illegal};
      chk("states", st, states);
      chk("length", lv, len);
      n = 0;
      while (done !== 1'b1 && n < 20) begin
        @(posedge clk);
        #1 n = n + 1;
      end
      chk("busy_span", st, n);
      if (n >= 20)
        report_and_stop;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_bits;
    integer i;
    reg [4:0] o;
    reg [1:0] k;
    begin
      run(`BSB_OP_SET_CARRY, 3'h0, 1'b0, 1'b0, 2'h3, 4'h1, 3'h1);
      chk("carry", 1'b1, carry);
      ecy = 1'b1;
      for (i = 0; i < 10; i = i + 1) begin
        o = `BSB_OP_AND_C + i / 2;
        k = i % 3;
        bit_in = (i % 4 == 1) || (i % 4 == 2);
        ecy = (o == `BSB_OP_AND_C) ? ecy & bit_in : (o == `BSB_OP_AND_NC) ? ecy & ~bit_in :
          (o == `BSB_OP_OR_C) ? ecy | bit_in : (o == `BSB_OP_OR_NC) ? ecy | ~bit_in : bit_in;
        run(o, 3'h0, i[0], i[1], k, tm(i[0], i[1], k, 1'b0), ln(i[0], i[1]));
        chk("carry", ecy, carry);
      end
      for (i = 0; i < 4; i = i + 1) begin
        o = (i == 3) ? `BSB_OP_MOV_FROM_C : `BSB_OP_CLR_BIT + i;
        k = i % 3;
        bit_in = i[0];
        run(o, 3'h0, i == 0, i[0], k, tm(i == 0, i[0], k, 1'b1), ln(i == 0, i[0]));
        chk("bit_out", i == 3 ? ecy : i == 2 ? !bit_in : i[0], bit_out);
        chk("bit_we", 1'b1, pl[6]);
      end
      $display("test bit operations done");
    end
  endtask

  task t_swap;
    begin
      run(`BSB_OP_SWAP, `BSB_FORM_DIR, 1'b0, 1'b0, `BSB_KIND_RAM, 4'h3, 3'h2);
      chk("acc_out", 8'hC3, acc_out);
      chk("mem_out", 8'h5A, mem_out);
      chk("swap_we", 2'h3, pl[5:4]);
      run(`BSB_OP_SWAP, `BSB_FORM_DIR, 1'b0, 1'b1, `BSB_KIND_PORT, 4'h5, 3'h2);
      run(`BSB_OP_SWAP, `BSB_FORM_DIR, 1'b0, 1'b0, `BSB_KIND_PSFR, 4'h6, 3'h2);
      run(`BSB_OP_SWAP, `BSB_FORM_IND, 1'b0, 1'b0, 2'h3, 4'h4, 3'h1);
      run(`BSB_OP_SWAP, `BSB_FORM_IND, 1'b0, 1'b1, 2'h3, 4'h5, 3'h2);
      run(`BSB_OP_SWAP_NIB, `BSB_FORM_IND, 1'b0, 1'b0, 2'h3, 4'h4, 3'h1);
      chk("acc_out", 8'h53, acc_out);
      chk("mem_out", 8'hCA, mem_out);
      run(`BSB_OP_SWAP_NIB, `BSB_FORM_IND, 1'b0, 1'b1, 2'h3, 4'h5, 3'h2);
      $display("test swap done");
    end
  endtask

  task stk(input [4:0] o, input [2:0] f, input s, input [1:0] k, input [3:0] st,
    input [2:0] lv, input [2:0] sz);
    reg [15:0] ea;
    reg ps;
    begin
      ps = (o == `BSB_OP_PUSH);
      ea = ps ? esp + 16'h1 : esp - sz + 16'h1;
      run(o, f, 1'b0, s, k, st, lv);
      esp = ps ? esp + sz : ea - 16'h1;
      chk("stk_addr", ea, stk_addr);
      chk("sp", esp, sp);
      chk("stk_size", sz, stk_size);
      chk("stk_strobe", ps ? 7'h08 : 7'h04, pl & 7'h0C);
    end
  endtask

  task t_stack;
    begin
      esp = `BSB_SP_RESET;
      chk("sp_reset", esp, sp);
      stk(`BSB_OP_PUSH, `BSB_FORM_WORD, 1'b0, 2'h3, 4'h5, 3'h3, 3'h2);
      stk(`BSB_OP_PUSH, `BSB_FORM_DWORD, 1'b1, 2'h3, 4'h8, 3'h2, 3'h4);
      stk(`BSB_OP_PUSH, `BSB_FORM_IMM16, 1'b1, 2'h3, 4'h5, 3'h4, 3'h2);
      chk("stk_data", opnd[15:0], stk_data[15:0]);
      stk(`BSB_OP_PUSH, `BSB_FORM_SDIR, 1'b0, `BSB_KIND_PSFR, 4'h4, 3'h2, 3'h1);
      stk(`BSB_OP_POP, `BSB_FORM_SDIR, 1'b1, `BSB_KIND_PORT, 4'h4, 3'h2, 3'h1);
      stk(`BSB_OP_POP, `BSB_FORM_WORD, 1'b1, 2'h3, 4'h4, 3'h2, 3'h2);
      stk(`BSB_OP_POP, `BSB_FORM_DWORD, 1'b0, 2'h3, 4'h9, 3'h3, 3'h4);
      stk(`BSB_OP_POP, `BSB_FORM_BYTE, 1'b0, 2'h3, 4'h3, 3'h3, 3'h1);
      // a request held through the busy window must be taken only once
      op = `BSB_OP_PUSH;
      form = `BSB_FORM_SDIR;
      kind = `BSB_KIND_RAM;
      start = 1'b1;
      repeat (3) @(posedge clk);
      #1 start = 1'b0;
      chk("done", 1'b1, done);
      chk("sp", esp + 16'h1, sp);
      @(posedge clk);
      #1 esp = esp + 16'h1;
      $display("test stack done");
    end
  endtask

  task t_branch;
    integer c, p;
    reg [9:0] tt;
    reg tk;
    reg [2:0] lv;
    reg [3:0] st;
    reg [4:0] o;
    begin
      // three flag sets, so that every condition is seen both taken and not taken
      for (p = 0; p < 3; p = p + 1) begin
        flag_z = (p == 1);
        flag_n = (p != 0);
        flag_ov = (p == 2);
        o = (p == 0) ? `BSB_OP_CLR_CARRY : `BSB_OP_SET_CARRY;
        run(o, 3'h0, 1'b0, 1'b0, 2'h3, 4'h1, 3'h1);
        tt = (p == 0) ? 10'h31A : (p == 1) ? 10'h0E5 : 10'h329;
        for (c = 0; c < 10; c = c + 1) begin
          cond = c;
          tk = tt[c];
          lv = (c < 2) ? 3'h2 : 3'h3;
          st = ((c < 2) ? 4'h1 : 4'h2) + (tk ? 4'h3 : 4'h0);
          run(`BSB_OP_BRANCH, 3'h0, 1'b0, 1'b0, 2'h3, st, lv);
          chk("taken", tk, taken);
          chk("next_pc", ipc + lv - (tk ? 24'h000004 : 24'h000000), next_pc);
        end
      end
      flag_z = 1'b0;
      flag_n = 1'b0;
      flag_ov = 1'b0;
      int_exec = 1'b1;
      dest_int = 1'b1;
      cond = `BSB_CC_NE;
      run(`BSB_OP_BRANCH, 3'h0, 1'b0, 1'b0, 2'h3, 4'h6, 3'h3);
      run(`BSB_OP_BRANCH, 3'h0, 1'b0, 1'b1, 2'h3, 4'h4, 3'h2);
      rel = 8'h05;
      run(`BSB_OP_BRANCH, 3'h0, 1'b0, 1'b1, 2'h3, 4'h5, 3'h2);
      chk("next_pc", 24'h000107, next_pc);
      cond = `BSB_CC_EQ;
      run(`BSB_OP_BRANCH, 3'h0, 1'b0, 1'b1, 2'h3, 4'h1, 3'h2);
      cond = 4'hC;
      run(`BSB_OP_BRANCH, 3'h0, 1'b0, 1'b0, 2'h3, 4'h1, 3'h3);
      chk("illegal", 1'b1, pl[0]);
      chk("taken", 1'b0, taken);
      chk("next_pc", 24'h000103, next_pc);
      $display("test branch done");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    t_stack;
    t_bits;
    t_swap;
    t_branch;
    report_and_stop;
  end
endmodule  // tb_bsb_exec
